// ==== ipav_pkg.sv ====
// Purpose: shared constants of the interrupt priority and autovector block
// Assumes: byte offsets on the register port, 32-bit data
// Notes:   one number per name; every file except the core model imports this package
package ipav_pkg;

    // sizes
    localparam int NUM_SRC = 10;
    localparam int NUM_LVL = 7;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int PEND_W  = 18;

    // register offsets
    localparam logic [7:0] OFS_PEND   = 8'h40;
    localparam logic [7:0] OFS_MASK   = 8'h44;
    localparam logic [7:0] OFS_AVR    = 8'h48;
    localparam logic [7:0] OFS_CTRL0  = 8'h4C;
    localparam logic [7:0] OFS_PINASN = 8'h58;
    localparam logic [7:0] OFS_ISTAT  = 8'h5C;
    localparam logic [7:0] OFS_IMASK  = 8'h60;
    localparam logic [7:0] OFS_WIN    = 8'h64;

    // field positions
    localparam int CTRL_AUTOVECTOR_SELECT_BIT = 7;
    localparam int CTRL_LVL_HI   = 4;
    localparam int CTRL_LVL_LO   = 2;
    localparam int CTRL_PRIO_HI  = 1;
    localparam int CTRL_PRIO_LO  = 0;
    localparam int PINASN_LO     = 5;
    localparam int AVR_BLK_BIT   = 0;
    localparam int PEND_INT_LO   = 8;
    localparam int PEND_EXT_LO   = 1;

    // writable bits and reset values
    localparam logic [7:0]  CTRL_WMASK = 8'h9F;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  AVR_RST    = 8'h00;
    localparam logic [2:0]  PINASN_RST = 3'h0;
    localparam logic [17:0] MASK_RST   = 18'h3_FFFE;
    localparam logic [17:0] MASK_WMASK = 18'h3_FFFE;
    localparam logic [2:0]  IMASK_RST  = 3'h0;

    // within-level order: 11 > 10 > pin > 01 > 00
    localparam logic [2:0] SUB_EXT    = 3'h2;
    localparam int         SUB_PER_LV = 5;

    // autovector offset = base + 4 * level
    localparam logic [7:0] VEC_BASE = 8'h60;

    // event bits of the status register
    localparam int EV_NEW  = 0;
    localparam int EV_ACK  = 1;
    localparam int EV_SPUR = 2;
    localparam int EV_W    = 3;

    typedef enum logic {ACK_IDLE, ACK_ANSWER} ipav_ack_e;

endpackage

// ==== ipav_rank.sv ====
// Purpose: picks the highest ranked request among 35 priority slots
// Assumes: requests already qualified by pending and mask
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module ipav_rank (
    // internal sources
    input  wire logic [ipav_pkg::NUM_SRC-1:0]   int_req_i,
    input  wire logic [ipav_pkg::NUM_SRC*8-1:0] int_ctrl_i,
    // external levels, bit n is level n+1
    input  wire logic [ipav_pkg::NUM_LVL-1:0]   ext_req_i,
    // winner
    output logic                                win_valid_o,
    output logic [2:0]                          win_level_o,
    output logic                                win_ext_o,
    output logic [3:0]                          win_src_o,
    output logic [5:0]                          win_rank_o
);
    import ipav_pkg::*;

    logic [5:0] best;
    logic [5:0] score;
    logic [2:0] lvl;
    logic [1:0] prio;
    logic [2:0] sub;

    always_comb begin
        best      = 6'h00;
        win_ext_o = 1'b0;
        win_src_o = 4'h0;
        score     = 6'h00;
        lvl       = 3'h0;
        prio      = 2'h0;
        sub       = 3'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl  = int_ctrl_i[i*8+CTRL_LVL_LO +: 3];
            prio = int_ctrl_i[i*8+CTRL_PRIO_LO +: 2];
            sub  = prio[1] ? {1'b0, prio} + 3'h1 : {1'b0, prio};
            score = {lvl, sub};
            // equal codes: lowest index wins, undefined anyway
            if (int_req_i[i] && lvl != 3'h0 && score > best) begin
                best      = score;
                win_ext_o = 1'b0;
                win_src_o = 4'(i);
            end
        end
        for (int l = 0; l < NUM_LVL; l++) begin
            score = {3'(l + 1), SUB_EXT};
            if (ext_req_i[l] && score > best) begin
                best      = score;
                win_ext_o = 1'b1;
                win_src_o = 4'h0;
            end
        end
        win_valid_o = best != 6'h00;
        win_level_o = best[5:3];
        // rank 1..35 from level and slot
        win_rank_o  = win_valid_o ?
            6'((7 - int'(best[5:3])) * SUB_PER_LV + SUB_PER_LV
               - int'(best[2:0])) : 6'h00;
    end

endmodule
`default_nettype wire

// ==== ipav_top.sv ====
// Purpose: interrupt ranking, pending/mask, autovector control, ack answer
// Assumes: request pins active low and asynchronous; sources synchronous
// Notes:   registers on a plain address/strobe port, read data one cycle on
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ipav_top (
    // clock, reset, enable
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          clk_en_i,
    // register port
    input  wire logic [ipav_pkg::ADDR_W-1:0]   reg_addr_i,
    input  wire logic [ipav_pkg::DATA_W-1:0]   reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [ipav_pkg::DATA_W-1:0]   reg_rdata_o,
    // internal source requests, same clock
    input  wire logic [ipav_pkg::NUM_SRC-1:0]  src_req_i,
    // external request pins, active low
    input  wire logic                          ext_request_pin_seven_n_i,
    input  wire logic                          ext_request_pin_five_n_i,
    input  wire logic                          ext_request_pin_three_n_i,
    input  wire logic                          ext_request_pin_one_n_i,
    // core side
    output logic      [2:0]                    irq_level_o,
    input  wire logic                          iack_i,
    input  wire logic [2:0]                    iack_level_i,
    output logic                               ack_valid_o,
    output logic                               ack_autovec_o,
    output logic      [7:0]                    ack_vector_o,
    output logic                               ack_strobe_block_o,
    output logic                               ack_spurious_o,
    // interrupt
    output logic                               int_o
);
    import ipav_pkg::*;

    // level requests from pins {7,5,3,1}; bit n is level n+1
    function automatic logic [6:0] ext_levels(input logic [3:0] p,
                                              input logic [2:0] a);
        logic [6:0] l;
        l = 7'h00;
        l[6] = p[3];
        l[4] = p[2] & ~a[2];
        l[3] = p[2] & a[2];
        l[2] = p[1] & ~a[1];
        l[5] = p[1] & a[1];
        l[0] = p[0] & ~a[0];
        l[1] = p[0] & a[0];
        return l;
    endfunction

    function automatic logic ctrl_hit(input logic [7:0] a);
        return a >= OFS_CTRL0 && a < OFS_CTRL0 + 8'(NUM_SRC);
    endfunction

    // pin synchroniser
    logic [3:0] pin_s1_q, pin_s1_d;
    logic [3:0] pin_s2_q, pin_s2_d;

    // registers
    logic [7:0]        ctrl_q [NUM_SRC];
    logic [7:0]        ctrl_d [NUM_SRC];
    logic [NUM_SRC*8-1:0] ctrl_flat;
    logic [7:0]        avr_q, avr_d;
    logic [2:0]        asn_q, asn_d;
    logic [PEND_W-1:0] pend_q, pend_d;
    logic [PEND_W-1:0] mask_q, mask_d;
    logic [EV_W-1:0]   stat_q, stat_d;
    logic [EV_W-1:0]   imask_q, imask_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    // winner
    logic       w_valid;
    logic [2:0] w_level;
    logic       w_ext;
    logic [3:0] w_src;
    logic [5:0] w_rank;
    logic       win_valid_q, win_valid_d;
    logic [2:0] win_level_q, win_level_d;
    logic       win_ext_q, win_ext_d;
    logic [3:0] win_src_q, win_src_d;
    logic [5:0] win_rank_q, win_rank_d;

    // acknowledge
    ipav_ack_e  ack_st_q, ack_st_d;
    logic       av_q, av_d;
    logic [7:0] vec_q, vec_d;
    logic       blk_q, blk_d;
    logic       spur_q, spur_d;
    logic [EV_W-1:0] ev;
    logic       ext_av;
    logic [7:0] lvl_asn;

    // sync: first stage only feeds the second
    always_comb begin
        pin_s1_d = ~{ext_request_pin_seven_n_i, ext_request_pin_five_n_i,
                     ext_request_pin_three_n_i, ext_request_pin_one_n_i};
        pin_s2_d = pin_s1_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else if (clk_en_i) begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
        end
    end

    for (genvar g = 0; g < NUM_SRC; g++) begin : g_flat
        assign ctrl_flat[g*8 +: 8] = ctrl_q[g];
    end

    // register writes and pending sampling
    always_comb begin
        avr_d  = avr_q;
        asn_d  = asn_q;
        mask_d = mask_q;
        for (int i = 0; i < NUM_SRC; i++) begin
            ctrl_d[i] = ctrl_q[i];
        end
        // pending samples every clock regardless of mask
        pend_d = {src_req_i, ext_levels(pin_s2_q, asn_q), 1'b0};
        if (reg_wr_i) begin
            if (ctrl_hit(reg_addr_i)) begin
                ctrl_d[4'(reg_addr_i - OFS_CTRL0)] =
                    reg_wdata_i[7:0] & CTRL_WMASK;
            end
            case (reg_addr_i)
                OFS_AVR:    avr_d  = reg_wdata_i[7:0];
                OFS_PINASN: asn_d  = reg_wdata_i[PINASN_LO +: 3];
                OFS_MASK:   mask_d = reg_wdata_i[PEND_W-1:0] & MASK_WMASK;
                default:    avr_d  = avr_d;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            avr_q  <= AVR_RST;
            asn_q  <= PINASN_RST;
            pend_q <= '0;
            mask_q <= MASK_RST;
            for (int i = 0; i < NUM_SRC; i++) begin
                ctrl_q[i] <= CTRL_RST;
            end
        end else if (clk_en_i) begin
            avr_q  <= avr_d;
            asn_q  <= asn_d;
            pend_q <= pend_d;
            mask_q <= mask_d;
            for (int i = 0; i < NUM_SRC; i++) begin
                ctrl_q[i] <= ctrl_d[i];
            end
        end
    end

    // masked requests never reach the ranking
    ipav_rank u_rank (
        .int_req_i   (pend_q[PEND_INT_LO +: NUM_SRC]
                      & ~mask_q[PEND_INT_LO +: NUM_SRC]),
        .int_ctrl_i  (ctrl_flat),
        .ext_req_i   (pend_q[PEND_EXT_LO +: NUM_LVL]
                      & ~mask_q[PEND_EXT_LO +: NUM_LVL]),
        .win_valid_o (w_valid),
        .win_level_o (w_level),
        .win_ext_o   (w_ext),
        .win_src_o   (w_src),
        .win_rank_o  (w_rank)
    );

    always_comb begin
        win_valid_d = w_valid;
        win_level_d = w_level;
        win_ext_d   = w_ext;
        win_src_d   = w_src;
        win_rank_d  = w_rank;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            win_valid_q <= 1'b0;
            win_level_q <= 3'h0;
            win_ext_q   <= 1'b0;
            win_src_q   <= 4'h0;
            win_rank_q  <= 6'h00;
        end else if (clk_en_i) begin
            win_valid_q <= win_valid_d;
            win_level_q <= win_level_d;
            win_ext_q   <= win_ext_d;
            win_src_q   <= win_src_d;
            win_rank_q  <= win_rank_d;
        end
    end

    assign irq_level_o = win_level_q;

    // bit honoured only for a level the pins are assigned to
    assign lvl_asn = {ext_levels(4'hF, asn_q), 1'b0};
    assign ext_av  = avr_q[win_level_q] & lvl_asn[win_level_q];

    // acknowledge answer, one cycle after the request
    always_comb begin
        ack_st_d = ACK_IDLE;
        av_d     = av_q;
        vec_d    = vec_q;
        blk_d    = blk_q;
        spur_d   = spur_q;
        ev       = '0;
        case (ack_st_q)
            ACK_IDLE: begin
                if (iack_i) begin
                    ack_st_d = ACK_ANSWER;
                    // a level the core names but no longer wins is spurious
                    spur_d = !win_valid_q || iack_level_i != win_level_q;
                    if (win_ext_q) begin
                        av_d = ext_av;
                    end else begin
                        av_d = ctrl_q[win_src_q][CTRL_AUTOVECTOR_SELECT_BIT];
                    end
                    if (spur_d) begin
                        av_d = 1'b0;
                    end
                    vec_d = VEC_BASE + {3'h0, win_level_q, 2'h0};
                    // block strobe on external autovector only
                    blk_d = av_d & win_ext_q & avr_q[AVR_BLK_BIT];
                    ev[EV_ACK]  = ~spur_d;
                    ev[EV_SPUR] = spur_d;
                end
            end
            ACK_ANSWER: ack_st_d = ACK_IDLE;
            default:    ack_st_d = ACK_IDLE;
        endcase
        ev[EV_NEW] = win_valid_d & ~win_valid_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ack_st_q <= ACK_IDLE;
            av_q     <= 1'b0;
            vec_q    <= 8'h00;
            blk_q    <= 1'b0;
            spur_q   <= 1'b0;
        end else if (clk_en_i) begin
            ack_st_q <= ack_st_d;
            av_q     <= av_d;
            vec_q    <= vec_d;
            blk_q    <= blk_d;
            spur_q   <= spur_d;
        end
    end

    assign ack_valid_o        = ack_st_q == ACK_ANSWER;
    assign ack_autovec_o      = av_q;
    assign ack_vector_o       = vec_q;
    assign ack_strobe_block_o = blk_q;
    assign ack_spurious_o     = spur_q;

    // status, interrupt mask and read data
    always_comb begin
        stat_d  = stat_q;
        imask_d = imask_q;
        rdata_d = '0;
        if (reg_wr_i && reg_addr_i == OFS_IMASK) begin
            imask_d = reg_wdata_i[EV_W-1:0];
        end
        if (reg_rd_i) begin
            if (ctrl_hit(reg_addr_i)) begin
                rdata_d[7:0] = ctrl_q[4'(reg_addr_i - OFS_CTRL0)];
            end
            case (reg_addr_i)
                OFS_PEND:   rdata_d[PEND_W-1:0] = pend_q;
                OFS_MASK:   rdata_d[PEND_W-1:0] = mask_q;
                OFS_AVR:    rdata_d[7:0] = avr_q;
                OFS_PINASN: rdata_d[PINASN_LO +: 3] = asn_q;
                OFS_ISTAT: begin
                    rdata_d[EV_W-1:0] = stat_q;
                    stat_d = '0;
                end
                OFS_IMASK:  rdata_d[EV_W-1:0] = imask_q;
                OFS_WIN:    rdata_d[9:0] = {win_valid_q, win_level_q,
                                            win_rank_q};
                default:    rdata_d = rdata_d;
            endcase
        end
        // a new event beats a clearing read
        stat_d = stat_d | ev;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            stat_q  <= '0;
            imask_q <= IMASK_RST;
            rdata_q <= '0;
        end else if (clk_en_i) begin
            stat_q  <= stat_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign int_o       = |(stat_q & imask_q);

endmodule
`default_nettype wire

// ==== ipav_top_asserts.sv ====
// Purpose: port checks for the interrupt ranking block
// Assumes: clk_en_i high whenever the checks run
// Notes:   bound into ipav_top after the module
`timescale 1ns/1ps
`default_nettype none
module ipav_top_asserts (
    // clock and reset
    input wire logic                        ref_clk_i,
    input wire logic                        rst_n_i,
    // register writes
    input wire logic [ipav_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [ipav_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic                        reg_wr_i,
    // core side
    input wire logic [2:0]                  irq_level_o,
    input wire logic                        iack_i,
    input wire logic [2:0]                  iack_level_i,
    input wire logic                        ack_valid_o,
    input wire logic                        ack_autovec_o,
    input wire logic [7:0]                  ack_vector_o,
    input wire logic                        ack_strobe_block_o,
    input wire logic                        ack_spurious_o
);
    import ipav_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // a request in the answer cycle is ignored, so it is no cause
    logic take;
    assign take = iack_i && !ack_valid_o;

    AST_ACK_NEXT:
        assert property (take |=> ack_valid_o)
        else $error("ack not answered");
    AST_ACK_ONE:
        assert property (ack_valid_o |=> !ack_valid_o)
        else $error("ack valid too long");
    AST_ACK_HOLD:
        assert property (!take |=> $stable({ack_autovec_o, ack_vector_o,
            ack_strobe_block_o, ack_spurious_o}))
        else $error("ack fields moved");
    AST_VEC_OFS:
        assert property (ack_valid_o && !ack_spurious_o |-> ack_vector_o
            == VEC_BASE + {3'h0, $past(iack_level_i), 2'h0})
        else $error("bad vector offset");
    AST_BLK_AV:
        assert property (ack_valid_o && ack_strobe_block_o
            |-> ack_autovec_o && !ack_spurious_o)
        else $error("strobe blocked off autovector");
    AST_SPUR_PLAIN:
        assert property (ack_valid_o && ack_spurious_o
            |-> !ack_autovec_o && !ack_strobe_block_o)
        else $error("spurious ack not plain");
    AST_SPUR_ZERO:
        assert property (ack_valid_o && $past(iack_level_i) == 3'h0
            |-> ack_spurious_o)
        else $error("level zero ack not spurious");
    AST_MASK_ALL:
        assert property (reg_wr_i && reg_addr_i == OFS_MASK
            && &reg_wdata_i[17:1] |-> ##2 irq_level_o == 3'h0)
        else $error("masked request reached core");

    CV_AUTO: cover property (ack_valid_o && ack_strobe_block_o);
    CV_SPUR: cover property (ack_valid_o && ack_spurious_o);
    CV_TOP: cover property (irq_level_o == 3'h7);
endmodule

bind ipav_top ipav_top_asserts u_asserts (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .irq_level_o(irq_level_o), .iack_i(iack_i),
    .iack_level_i(iack_level_i), .ack_valid_o(ack_valid_o),
    .ack_autovec_o(ack_autovec_o), .ack_vector_o(ack_vector_o),
    .ack_strobe_block_o(ack_strobe_block_o),
    .ack_spurious_o(ack_spurious_o)
);
`default_nettype wire

// ==== ipav_core_model.sv ====
// Purpose: behavioural core that takes interrupts from the block
// Assumes: one acknowledge outstanding at a time
// Notes:   wrong_i acks level zero to draw a spurious answer
`timescale 1ns/1ps
`default_nettype none
module ipav_core_model (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // bench controls
    input  wire logic       enable_i,
    input  wire logic       wrong_i,
    input  wire logic [3:0] gap_i,
    output var  logic [7:0] acks_o,
    // block side
    input  wire logic [2:0] irq_level_i,
    input  wire logic       ack_valid_i,
    output var  logic       iack_o,
    output var  logic [2:0] iack_level_o
);
    initial begin
        iack_o = 1'b0;
        iack_level_o = 3'h0;
        acks_o = 8'h0;
        forever begin
            @(posedge ref_clk_i);
            if (rst_n_i && enable_i && irq_level_i != 3'h0) begin
                repeat (gap_i) @(posedge ref_clk_i);
                iack_o <= 1'b1;
                iack_level_o <= wrong_i ? 3'h0 : irq_level_i;
                @(posedge ref_clk_i);
                iack_o <= 1'b0;
                // released level line must not keep its last value
                iack_level_o <= ~iack_level_o;
                @(posedge ref_clk_i);
                if (ack_valid_i) begin
                    acks_o <= acks_o + 8'h1;
                end
            end else begin
                iack_level_o <= ~iack_level_o;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb_ipav.sv ====
// Purpose: self-checking bench for the interrupt ranking block
// Assumes: clk_en_i held high; core model answers on the ack side
// Notes:   a fixed settle of five cycles covers the pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ipav_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        clk_en_i = 1'b1;
    logic [7:0]  reg_addr_i = 8'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [9:0]  src_req_i = 10'h0;
    logic [3:0]  pin_n = 4'hF;
    logic        core_en = 1'b0;
    logic        core_bad = 1'b0;
    logic [3:0]  core_gap = 4'h0;
    logic [31:0] reg_rdata_o;
    logic [2:0]  irq_level_o, iack_level_i, lvl_rd;
    logic [7:0]  ack_vector_o, acks;
    logic        iack_i, ack_valid_o, ack_autovec_o, int_o;
    logic        ack_strobe_block_o, ack_spurious_o;
    int          errors = 0;
    int          n_checks = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    ipav_top uut (
        .ref_clk_i, .rst_n_i, .clk_en_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .src_req_i,
        .ext_request_pin_seven_n_i(pin_n[3]),
        .ext_request_pin_five_n_i(pin_n[2]),
        .ext_request_pin_three_n_i(pin_n[1]),
        .ext_request_pin_one_n_i(pin_n[0]),
        .irq_level_o, .iack_i, .iack_level_i, .ack_valid_o, .ack_autovec_o,
        .ack_vector_o, .ack_strobe_block_o, .ack_spurious_o, .int_o
    );
    ipav_core_model core (
        .ref_clk_i, .rst_n_i, .enable_i(core_en), .wrong_i(core_bad),
        .gap_i(core_gap), .acks_o(acks), .irq_level_i(irq_level_o),
        .ack_valid_i(ack_valid_o), .iack_o(iack_i),
        .iack_level_o(iack_level_i)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        // spare edge: back-to-back writes never reassign the strobe
        @(posedge ref_clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input logic [31:0] m = 32'hFFFF_FFFF);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        lvl_rd = irq_level_o;
        chk(reg_rdata_o & m, exp);
        @(posedge ref_clk_i);
    endtask
    task automatic settle();
        repeat (5) @(posedge ref_clk_i);
    endtask
    task automatic win(input int rk);
        logic [2:0] lv;
        lv = (rk == 0) ? 3'h0 : 3'(7 - (rk - 1) / 5);
        rdc(OFS_WIN, (rk == 0) ? 32'h0 : {22'h0, 1'b1, lv, 6'(rk)});
        chk(32'(lvl_rd), 32'(lv));
    endtask
    // lets the core take one ack, then compares the held answer
    task automatic ack_chk(input logic [2:0] exp, input logic [7:0] vec);
        logic [7:0] c0;
        // the winner must be stable before the core may take it
        settle();
        c0 = acks;
        core_en <= 1'b1;
        for (int i = 0; i < 40 && acks == c0; i++) @(posedge ref_clk_i);
        core_en <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        chk(32'(acks != c0), 32'h1);
        chk(32'({ack_autovec_o, ack_strobe_block_o, ack_spurious_o}),
            32'(exp));
        if (vec != 8'h0) chk(32'(ack_vector_o), 32'(vec));
    endtask

    task automatic t_regs();
        rdc(OFS_MASK, 32'h0003_FFFE);
        rdc(OFS_AVR, 32'h0);
        rdc(8'h00, 32'h0);
        wr(OFS_CTRL0 + 8'h9, 32'hFFFF_FFFF);
        rdc(OFS_CTRL0 + 8'h9, 32'h0000_009F);
        wr(OFS_AVR, 32'hFFFF_FFFF);
        rdc(OFS_AVR, 32'h0000_00FF);
        wr(OFS_PINASN, 32'hFFFF_FFFF);
        rdc(OFS_PINASN, 32'h0000_00E0);
        wr(OFS_CTRL0 + 8'h9, 32'h0);
        wr(OFS_AVR, 32'h0);
    endtask
    task automatic t_rank();
        wr(OFS_CTRL0, 32'h0000_0017);
        wr(OFS_CTRL0 + 8'h4, 32'h0000_0019);
        wr(OFS_CTRL0 + 8'h5, 32'h0000_001A);
        wr(OFS_PINASN, 32'h0000_0040);
        src_req_i <= 10'h031;
        pin_n[1] <= 1'b0;
        settle();
        rdc(OFS_PEND, 32'h0000_3140);
        win(0);
        wr(OFS_MASK, 32'h0);
        win(7);
        src_req_i <= 10'h011;
        settle();
        win(8);
        pin_n[1] <= 1'b1;
        settle();
        win(9);
        src_req_i <= 10'h001;
        settle();
        win(11);
        src_req_i <= 10'h0;
        settle();
        win(0);
    endtask
    task automatic t_pins();
        int pin_t[7] = '{3, 2, 2, 1, 1, 0, 0};
        int asn_t[7] = '{0, 0, 4, 0, 2, 0, 1};
        int rk_t[7] = '{3, 13, 18, 23, 8, 33, 28};
        for (int k = 0; k < 7; k++) begin
            wr(OFS_PINASN, 32'(asn_t[k] << 5));
            pin_n[pin_t[k]] <= 1'b0;
            settle();
            win(rk_t[k]);
            pin_n <= 4'hF;
            settle();
        end
    endtask
    task automatic t_ack();
        wr(OFS_PINASN, 32'h0000_0040);
        pin_n[1] <= 1'b0;
        wr(OFS_AVR, 32'h0000_0041);
        core_gap <= 4'h3;
        ack_chk(3'h6, 8'h78);
        core_gap <= 4'h0;
        wr(OFS_AVR, 32'h0000_0001);
        ack_chk(3'h0, 8'h78);
        pin_n[1] <= 1'b1;
        wr(OFS_CTRL0 + 8'h2, 32'h0000_0095);
        src_req_i <= 10'h004;
        ack_chk(3'h4, 8'h74);
        core_bad <= 1'b1;
        ack_chk(3'h1, 8'h0);
        core_bad <= 1'b0;
        src_req_i <= 10'h0;
        settle();
    endtask
    task automatic t_irq();
        chk(32'(int_o), 32'h0);
        rdc(OFS_ISTAT, 32'h0000_0006, 32'h0000_0006);
        rdc(OFS_ISTAT, 32'h0, 32'h0000_0007);
        wr(OFS_IMASK, 32'h0000_0001);
        src_req_i <= 10'h001;
        settle();
        chk(32'(int_o), 32'h1);
        rdc(OFS_ISTAT, 32'h0000_0001, 32'h0000_0007);
        settle();
        chk(32'(int_o), 32'h0);
        src_req_i <= 10'h0;
        wr(OFS_MASK, 32'h0003_FFFE);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_rank();
        t_pins();
        t_ack();
        t_irq();
        summarize();
    end
    initial begin
        #200_000;
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
